// [dimmer_pkg.sv]
// Shared constants for the pulse-counting LED dimmer link
// Notes on behaviour
// - Count rising edges into 32 one-dB levels
// - Code 32 full scale, code 1 minus 31dB
// - Counter wraps from level 32 to 1
// - Each edge after enable adds one dB
// - Host lowers one step with 31 pulses
// - Pulse rates up to one megahertz accepted
// - First edge enables and loads lowest level
// - Line held high keeps programmed current
// - Low for off timeout disables all outputs
// - Pulses counted during soft start interval
// - Single pulses allowed, low phase below timeout
// - Logarithmic table from 0.549 to 20 mA
// - One code drives every current output together
// - Host high phase at least 50 ns
package dimmer_pkg;

    // ------------------------------------------------------------
    // Levels and timing
    // ------------------------------------------------------------
    localparam int LEVEL_W = 5;
    localparam int NUM_LEVELS = 32;
    localparam int NUM_OUTPUTS_DEF = 4;
    localparam int PTR_W = 4;
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_OFF_NS = 500000;
    localparam int T_SS_NS = 400000;
    localparam int T_PULSE_PERIOD_NS = 1000;
    localparam int T_HIGH_MIN_NS = 50;
    // Longest time rounds down
    localparam int OFF_CYC = T_OFF_NS / CLK_PERIOD_NS;
    localparam int SS_CYC = T_SS_NS / CLK_PERIOD_NS;
    // Least times round up
    localparam int HALF_CYC = (T_PULSE_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_MIN_CYC = (T_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOST_OFF_MARGIN_CYC = 100;
    localparam int CNT_W = 16;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 5'h00;

    // ------------------------------------------------------------
    // Output current per level index (code minus one), microamps
    // ------------------------------------------------------------
    localparam logic [15:0] CURRENT_UA [NUM_LEVELS] = '{
        16'd549, 16'd627, 16'd706, 16'd784, 16'd863, 16'd1020, 16'd1098, 16'd1255,
        16'd1412, 16'd1569, 16'd1804, 16'd1961, 16'd2275, 16'd2510, 16'd2824, 16'd3137,
        16'd3529, 16'd4000, 16'd4471, 16'd5020, 16'd5647, 16'd6353, 16'd7059, 16'd7922,
        16'd8941, 16'd10039, 16'd11216, 16'd12627, 16'd14118, 16'd15843, 16'd17804,
        16'd20000
    };

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LOW = 2'b01,
        H_HIGH = 2'b10,
        H_OFF = 2'b11
    } host_state_t;

endpackage : dimmer_pkg

// [dimmer_link_if.sv]
// Single control line between the host and the dimmer
`timescale 1ns/1ns
interface dimmer_link_if;
    logic pulse_line;
    modport device (input pulse_line);
    modport host (output pulse_line);
endinterface : dimmer_link_if

// [dimmer_device.sv]
// Dimmer end: edge counter on the line, level and timeout on clk
`timescale 1ns/1ns
module dimmer_device #(
    parameter int NUM_OUTPUTS = dimmer_pkg::NUM_OUTPUTS_DEF,
    parameter int OFF_CYCLES = dimmer_pkg::OFF_CYC,
    parameter int SS_CYCLES = dimmer_pkg::SS_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    dimmer_link_if.device link,
    output logic led_enabled,
    output logic [dimmer_pkg::LEVEL_W-1:0] level_code,
    output logic soft_start_active,
    output logic [NUM_OUTPUTS-1:0][15:0] led_output_current
);
    import dimmer_pkg::*;

    // ------------------------------------------------------------
    // Link domain: the line itself clocks a gray edge pointer
    // ------------------------------------------------------------
    logic [PTR_W-1:0] edge_bin_q;
    logic [PTR_W-1:0] edge_gray_q;
    wire [PTR_W-1:0] edge_bin_d = edge_bin_q + 4'h1;

    always_ff @(posedge link.pulse_line or posedge sys_rst) begin
        if (sys_rst) begin
            edge_bin_q <= '0;
            edge_gray_q <= '0;
        end else begin
            edge_bin_q <= edge_bin_d;
            edge_gray_q <= edge_bin_d ^ (edge_bin_d >> 1);
        end
    end

    // ------------------------------------------------------------
    // Crossing into clk: three stages, take when two and three agree
    // ------------------------------------------------------------
    logic [PTR_W-1:0] g1_q;
    logic [PTR_W-1:0] g2_q;
    logic [PTR_W-1:0] g3_q;
    logic [PTR_W-1:0] gray_ok_q;
    logic [PTR_W-1:0] seen_q;
    logic l1_q;
    logic l2_q;
    logic l3_q;
    logic line_ok_q;

    // Gray pointer: one bit moves per edge, so a torn sample is harmless
    wire gray_agree = (g2_q == g3_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            g1_q <= '0;
            g2_q <= '0;
            g3_q <= '0;
        end else if (ce) begin
            g1_q <= edge_gray_q;
            g2_q <= g1_q;
            g3_q <= g2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gray_ok_q <= '0;
        end else if (ce && gray_agree) begin
            gray_ok_q <= g3_q;
        end
    end

    // Line level, used only for the low timeout
    wire line_agree = (l2_q == l3_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            l1_q <= 1'b0;
            l2_q <= 1'b0;
            l3_q <= 1'b0;
        end else if (ce) begin
            l1_q <= link.pulse_line;
            l2_q <= l1_q;
            l3_q <= l2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            line_ok_q <= 1'b0;
        end else if (ce && line_agree) begin
            line_ok_q <= l3_q;
        end
    end

    logic [PTR_W-1:0] ptr_bin;
    always_comb begin
        ptr_bin[PTR_W-1] = gray_ok_q[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--) begin
            ptr_bin[i] = ptr_bin[i+1] ^ gray_ok_q[i];
        end
    end

    wire [PTR_W-1:0] new_edges = ptr_bin - seen_q;
    wire edge_seen = (new_edges != '0);

    // ------------------------------------------------------------
    // Level code, enable, timeout and soft start
    // ------------------------------------------------------------
    logic enabled_q;
    logic [LEVEL_W-1:0] level_q;
    logic [CNT_W-1:0] low_cnt_q;
    logic [CNT_W-1:0] ss_cnt_q;

    wire timeout = !line_ok_q && (low_cnt_q >= CNT_W'(OFF_CYCLES - 1));
    // Modulo wrap from 32 to 1
    wire [LEVEL_W-1:0] level_add = level_q + LEVEL_W'(new_edges);
    // First edge loads the lowest level
    wire [LEVEL_W-1:0] level_first = LEVEL_W'(new_edges - 4'h1);
    // Step up one dB per edge
    wire [LEVEL_W-1:0] level_next = enabled_q ? level_add : level_first;
    wire low_clear = line_ok_q || edge_seen;
    wire low_step = !low_clear && !timeout;
    // Disable clears code, an edge in the same cycle wins
    wire go_off = !edge_seen && timeout;
    wire ss_load = edge_seen && !enabled_q;
    wire ss_clear = !enabled_q || go_off;
    wire ss_run = (ss_cnt_q != '0);

    // ------------------------------------------------------------
    // Edge bookkeeping and low timeout
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seen_q <= '0;
        end else if (ce) begin
            seen_q <= ptr_bin;
        end
    end

    // Saturates at the timeout so the count cannot wrap back
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cnt_q <= '0;
        end else if (ce && low_clear) begin
            low_cnt_q <= '0;
        end else if (ce && low_step) begin
            low_cnt_q <= low_cnt_q + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // Enable, level and soft start
    // ------------------------------------------------------------
    // Off after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enabled_q <= 1'b0;
            level_q <= LEVEL_RESET;
        end else if (ce && edge_seen) begin
            enabled_q <= 1'b1;
            level_q <= level_next;
        end else if (ce && go_off) begin
            enabled_q <= 1'b0;
            level_q <= LEVEL_RESET;
        end
    end

    // Soft start only flags the ramp, edges keep counting
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ss_cnt_q <= '0;
        end else if (ce && ss_load) begin
            ss_cnt_q <= CNT_W'(SS_CYCLES);
        end else if (ce && ss_clear) begin
            ss_cnt_q <= '0;
        end else if (ce && ss_run) begin
            ss_cnt_q <= ss_cnt_q - 16'h1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [NUM_OUTPUTS-1:0][15:0] cur_q;
    wire [15:0] cur_sel = enabled_q ? CURRENT_UA[level_q] : 16'h0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_q <= '0;
        end else if (ce) begin
            for (int k = 0; k < NUM_OUTPUTS; k++) begin
                cur_q[k] <= cur_sel;
            end
        end
    end

    // Index 31 is code 32, full scale
    assign level_code = level_q;
    assign led_enabled = enabled_q;
    assign soft_start_active = (ss_cnt_q != '0);
    assign led_output_current = cur_q;

endmodule : dimmer_device

// [dimmer_host.sv]
// Host end: turns a requested level into a burst on the line
`timescale 1ns/1ns
module dimmer_host #(
    parameter int HALF_CYCLES = dimmer_pkg::HALF_CYC,
    parameter int OFF_HOLD_CYCLES = dimmer_pkg::OFF_CYC + dimmer_pkg::HOST_OFF_MARGIN_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    dimmer_link_if.host link,
    input wire logic req_valid,
    input wire logic req_off,
    input wire logic [dimmer_pkg::LEVEL_W-1:0] req_level,
    output logic req_ready,
    output logic host_enabled,
    output logic [dimmer_pkg::LEVEL_W-1:0] host_level
);
    import dimmer_pkg::*;

    host_state_t state_q, state_d;
    logic line_q;
    logic en_q;
    logic [LEVEL_W-1:0] lvl_q;
    logic [5:0] left_q;
    logic [CNT_W-1:0] tim_q;

    // ------------------------------------------------------------
    // Pulses needed to reach the requested level
    // ------------------------------------------------------------
    // Going down relies on the modulo wrap
    wire [LEVEL_W-1:0] step = req_level - lvl_q;
    wire [5:0] need = en_q ? {1'b0, step} : 6'(req_level) + 6'h01;
    wire take = (state_q == H_IDLE) && req_valid;
    wire start_off = take && req_off && en_q;
    wire start_burst = take && !req_off && (need != 6'h00);
    // High phase well above its minimum
    wire half_done = (tim_q >= CNT_W'(HALF_CYCLES - 1));
    wire off_done = (tim_q >= CNT_W'(OFF_HOLD_CYCLES - 1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            H_IDLE: begin
                if (start_off) begin
                    state_d = H_OFF;
                end else if (start_burst) begin
                    state_d = H_LOW;
                end
            end
            // Low phase far below the timeout
            H_LOW: begin
                if (half_done) begin
                    state_d = H_HIGH;
                end
            end
            H_HIGH: begin
                if (half_done) begin
                    state_d = (left_q == 6'h01) ? H_IDLE : H_LOW;
                end
            end
            H_OFF: begin
                if (off_done) begin
                    state_d = H_IDLE;
                end
            end
            default: begin
                state_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= H_IDLE;
            line_q <= 1'b0;
            en_q <= 1'b0;
            lvl_q <= LEVEL_RESET;
            left_q <= 6'h00;
            tim_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            tim_q <= (state_d != state_q) ? '0 : tim_q + 16'h1;
            if (start_burst) begin
                left_q <= need;
                lvl_q <= req_level;
                en_q <= 1'b1;
            end else if (state_q == H_HIGH && half_done) begin
                left_q <= left_q - 6'h01;
            end
            if (start_off) begin
                en_q <= 1'b0;
                lvl_q <= LEVEL_RESET;
            end
            // Line stays high after the last pulse
            if (state_d == H_LOW || state_d == H_OFF) begin
                line_q <= 1'b0;
            end else if (state_d == H_HIGH) begin
                line_q <= 1'b1;
            end
        end
    end

    assign link.pulse_line = line_q;
    assign req_ready = (state_q == H_IDLE);
    assign host_enabled = en_q;
    assign host_level = lvl_q;

endmodule : dimmer_host

// [dimmer_link_sva.sv]
// Concurrent checks on the dimmer link and the device outputs
`timescale 1ns/1ns
module dimmer_link_sva #(
    parameter int NUM_OUTPUTS = dimmer_pkg::NUM_OUTPUTS_DEF,
    parameter int OFF_CYCLES = dimmer_pkg::OFF_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pulse_line,
    input wire logic led_enabled,
    input wire logic [dimmer_pkg::LEVEL_W-1:0] level_code,
    input wire logic [NUM_OUTPUTS-1:0][15:0] led_output_current
);
    import dimmer_pkg::*;
    logic [15:0] low_cnt_q;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Consecutive low cycles of the line
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || pulse_line) begin
            low_cnt_q <= 16'h0000;
        end else if (low_cnt_q != 16'hffff) begin
            low_cnt_q <= low_cnt_q + 16'h0001;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_off_level_zero: assert property (!led_enabled |-> level_code == 5'h00)
        else $error("level not cleared while off");
    a_off_no_current: assert property (!led_enabled [*2] |-> led_output_current[0] == 16'h0000)
        else $error("current flows while off");
    a_outputs_match: assert property (led_output_current[0] == led_output_current[NUM_OUTPUTS-1])
        else $error("outputs differ");
    a_full_scale_code: assert property (led_enabled && level_code == 5'h1f |=> led_output_current[0] == 16'd20000)
        else $error("full scale current wrong");
    a_lowest_code: assert property (led_enabled && level_code == 5'h00 |=> led_output_current[0] == 16'd549)
        else $error("lowest current wrong");
    a_enable_code_one: assert property ($rose(led_enabled) |-> level_code == 5'h00)
        else $error("enable did not load lowest code");
    a_high_holds: assert property (pulse_line [*8] |-> led_enabled && $stable(level_code))
        else $error("level moved while line high");
    a_short_low_keeps: assert property (led_enabled && $fell(pulse_line) |=> (led_enabled && $stable(level_code)) [*8])
        else $error("short low changed state");
    a_timeout_window: assert property ($fell(led_enabled) |-> int'(low_cnt_q) >= OFF_CYCLES - 1 && int'(low_cnt_q) <= OFF_CYCLES + 12)
        else $error("disable outside timeout window");
    a_long_low_off: assert property (int'(low_cnt_q) == OFF_CYCLES + 12 |-> !led_enabled)
        else $error("still on after timeout");
endmodule : dimmer_link_sva

// [pulse_count_led_dimmer_tb_top.sv]
// Bench joining host and device ends over the single control line
`timescale 1ns/1ns
module pulse_count_led_dimmer_tb_top;
    import dimmer_pkg::*;
    localparam int OFF_C = 200;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic req_valid = 1'b0;
    logic req_off = 1'b0;
    logic [LEVEL_W-1:0] req_level = 5'h00;
    logic req_ready, led_enabled, soft_start_active, host_enabled;
    logic [LEVEL_W-1:0] level_code, host_level;
    logic [3:0][15:0] led_output_current;
    int err_total = 0;
    int tests_run = 0;
    int edges = 0;
    logic en_m = 1'b0;
    logic [LEVEL_W-1:0] lvl_m = 5'h00;
    dimmer_link_if lnk ();
    dimmer_host #(.HALF_CYCLES(10), .OFF_HOLD_CYCLES(220)) dimmer_host_i (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .link(lnk), .req_valid(req_valid),
        .req_off(req_off), .req_level(req_level), .req_ready(req_ready),
        .host_enabled(host_enabled), .host_level(host_level));
    dimmer_device #(.NUM_OUTPUTS(4), .OFF_CYCLES(OFF_C), .SS_CYCLES(1000)) dimmer_device_i (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .link(lnk), .led_enabled(led_enabled),
        .level_code(level_code), .soft_start_active(soft_start_active),
        .led_output_current(led_output_current));
    dimmer_link_sva #(.NUM_OUTPUTS(4), .OFF_CYCLES(OFF_C)) dimmer_link_sva_i (
        .clk(clk), .sys_rst(sys_rst), .pulse_line(lnk.pulse_line),
        .led_enabled(led_enabled), .level_code(level_code),
        .led_output_current(led_output_current));
    always #25 clk = ~clk;
    always @(posedge lnk.pulse_line) edges = edges + 1;
    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    function automatic int pulses(input logic en, input logic [4:0] cur, input logic [4:0] tgt);
        return en ? int'(5'(tgt - cur)) : int'(tgt) + 1;
    endfunction : pulses
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    // One request through the host, then device state compared
    task automatic op(input logic off, input logic [4:0] lvl);
        int n;
        int w;
        n = off ? 0 : pulses(en_m, lvl_m, lvl);
        w = 0;
        edges = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_off <= off;
        req_level <= lvl;
        @(posedge clk);
        req_valid <= 1'b0;
        do begin
            @(negedge clk);
            w++;
        end while (req_ready !== 1'b1 && w < 2000);
        if (w >= 2000) err_total++;
        repeat (12) @(negedge clk);
        en_m = !off;
        lvl_m = off ? 5'h00 : lvl;
        chk("edges", 32'(edges), 32'(n));
        chk("enabled", {31'h0, led_enabled}, {31'h0, en_m});
        chk("level", {27'h0, level_code}, {27'h0, lvl_m});
        chk("current", {16'h0, led_output_current[3]}, en_m ? {16'h0, CURRENT_UA[lvl_m]} : 32'h0);
        chk("host_enabled", {31'h0, host_enabled}, {31'h0, en_m});
        chk("host_level", {27'h0, host_level}, {27'h0, lvl_m});
    endtask : op
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        void'($urandom(54));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk("reset_off", {15'h0, led_enabled, led_output_current[0]}, 32'h0);
        op(1'b0, 5'h1f);
        chk("soft_start", {31'h0, soft_start_active}, 32'h1);
        op(1'b0, 5'h00);
        op(1'b0, 5'h00);
        op(1'b0, 5'h1e);
        op(1'b0, 5'h1d);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        en_m = 1'b0;
        lvl_m = 5'h00;
        @(negedge clk);
        chk("reset_mid", {15'h0, led_enabled, led_output_current[0]}, 32'h0);
        op(1'b0, 5'h05);
        // Nothing moves while clock enable is low
        @(posedge clk);
        ce <= 1'b0;
        req_valid <= 1'b1;
        req_level <= 5'h10;
        repeat (30) @(posedge clk);
        req_valid <= 1'b0;
        ce <= 1'b1;
        @(negedge clk);
        chk("ce_host_level", {27'h0, host_level}, 32'h5);
        chk("ce_level", {27'h0, level_code}, 32'h5);
        op(1'b1, 5'h00);
        op(1'b1, 5'h00);
        chk("soft_start_off", {31'h0, soft_start_active}, 32'h0);
        repeat (10) op($urandom_range(3) == 0, 5'($urandom));
        print_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule : pulse_count_led_dimmer_tb_top
